// ==== common/arb_pkg.sv ====
// Constants, register map and types for the bus arbitration controller
//
// Functional notes
// - Controller function selectable, or disabled.
// - Round-robin, single-level or fixed priority arbitration.
// - Controller drives system clock and acknowledge chain.
// - Controller times out stalled data transfers.
// - Grant not taken up within period flags timeout.
// - Slot one detected enables controller automatically.
// - Request on software-chosen level, take control.
// - Release on request, when done, or hold.
// - Panel reset resets board, drives system reset only when controller enabled.
package arb_pkg;
	// Register byte offsets
	localparam logic [11:0] ctrl_off = 12'h000;
	localparam logic [11:0] stat_off = 12'h004;
	// Control field positions
	localparam int ctl_sc_force_bit = 0;
	localparam int ctl_sc_disable_bit = 1;
	localparam int ctl_mode_lsb = 2;
	localparam int ctl_arb_to_lsb = 4;
	localparam int ctl_level_lsb = 6;
	localparam int ctl_policy_lsb = 8;
	localparam int ctl_req_bit = 10;
	localparam int ctl_bto_lsb = 12;
	localparam logic [31:0] ctrl_reset = 32'h0000_4000;
	// Status: write one to clear bits 0 and 1
	localparam int st_arb_to_bit = 0;
	localparam int st_bus_to_bit = 1;
	localparam int st_sc_bit = 2;
	localparam int st_owner_bit = 3;
	localparam int st_granted_lsb = 4;
	// Timing
	localparam int clk_mhz = 50;
	localparam int arb_to_16_us = 16;
	localparam int arb_to_64_us = 64;
	localparam int arb_to_256_us = 256;
	localparam int arb_to_1_ms = 1;
	localparam int cyc_16 = arb_to_16_us * clk_mhz;
	localparam int cyc_64 = arb_to_64_us * clk_mhz;
	localparam int cyc_256 = arb_to_256_us * clk_mhz;
	localparam int cyc_1ms = arb_to_1_ms * 1000 * clk_mhz;
	localparam int bto_unit_us = 8;
	localparam int bto_unit_cyc = bto_unit_us * clk_mhz;
	localparam int sysclk_half_cyc = 2;
	localparam int reset_stretch_cyc = 16;

	typedef enum logic [1:0] {
		round_robin_arbitration,
		single_level_arbitration,
		priority_arbitration
	} arb_mode_e;

	typedef enum logic [1:0] {
		release_on_request_policy,
		release_when_done_policy,
		capture_and_hold_policy
	} rel_policy_e;

	typedef enum logic [1:0] {
		req_idle,
		req_wait,
		req_own
	} req_state_e;
endpackage

// ==== logic/arb_ctrl.sv ====
// Bus arbitration controller: system controller arbiter plus requester
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module arb_ctrl #(
	parameter int timeout_1ms_cyc = arb_pkg::cyc_1ms
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slot1_n,
	input wire logic [3:0] bus_req_n,
	input wire logic bus_busy_n,
	input wire logic data_strobe_n,
	input wire logic dtack_n,
	input wire logic panel_reset_n,
	input wire logic xfer_done,
	output logic [3:0] bus_grant_n,
	output logic [3:0] own_req_n,
	output logic own_busy_n,
	output logic bus_owner,
	output logic sysclk,
	output logic iack_chain_n,
	output logic bus_error_n,
	output logic sysreset_n,
	output logic board_reset_n
);
	// Whole state of the block, registered in one process
	typedef struct packed {
		logic [1:0] slot1_s;
		logic [1:0] slot1_q;
		logic [7:0] breq_s;
		logic [3:0] breq_q;
		logic [1:0] bbsy_s;
		logic [1:0] bbsy_q;
		logic [1:0] ds_s;
		logic [1:0] ds_q;
		logic [1:0] dtk_s;
		logic [1:0] dtk_q;
		logic [1:0] pnl_s;
		logic [1:0] pnl_q;
		logic [31:0] ctrl;
		logic arb_to;
		logic bus_to;
		logic slot1_seen;
		logic [3:0] grant;
		logic [1:0] rr_last;
		logic [31:0] gcnt;
		logic [15:0] bcnt;
		logic [1:0] sclk_div;
		logic sclk;
		logic [4:0] rst_cnt;
		arb_pkg::req_state_e rstate;
		logic [31:0] rdata;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	logic sc_en;
	logic [1:0] mode;
	logic [1:0] lvl;
	logic [1:0] policy;
	logic [31:0] grant_limit;
	logic [3:0] reqs;
	logic [1:0] pick;
	logic pick_ok;
	logic wr_acc;
	logic rd_acc;
	logic other_req;

	// slot one enable
	// Slot one is strapped after reset; software may force or disable.
	assign sc_en = !st_r.ctrl[arb_pkg::ctl_sc_disable_bit] &&
		(st_r.slot1_seen || st_r.ctrl[arb_pkg::ctl_sc_force_bit]);
	assign mode = st_r.ctrl[arb_pkg::ctl_mode_lsb +: 2];
	assign lvl = st_r.ctrl[arb_pkg::ctl_level_lsb +: 2];
	assign policy = st_r.ctrl[arb_pkg::ctl_policy_lsb +: 2];
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && !penable && !pwrite;
	assign reqs = st_r.breq_q;
	// Another board wants the bus on any level but ours
	assign other_req = |(reqs & ~(4'h1 << lvl));

	always_comb begin
		case (st_r.ctrl[arb_pkg::ctl_arb_to_lsb +: 2])
			2'h0: grant_limit = 32'(arb_pkg::cyc_16);
			2'h1: grant_limit = 32'(arb_pkg::cyc_64);
			2'h2: grant_limit = 32'(arb_pkg::cyc_256);
			default: grant_limit = 32'(timeout_1ms_cyc);
		endcase
	end

	always_comb begin
		pick = 2'h0;
		pick_ok = 1'b0;
		if (mode == 2'(arb_pkg::single_level_arbitration)) begin
			pick = 2'h3;
			pick_ok = reqs[3];
		end else if (mode == 2'(arb_pkg::priority_arbitration)) begin
			for (int i = 0; i < 4; i++) begin
				if (reqs[i]) begin
					pick = 2'(i);
					pick_ok = 1'b1;
				end
			end
		end else begin
			// Round robin: search downward from the level below the last
			for (int k = 4; k >= 1; k--) begin
				if (reqs[2'(st_r.rr_last - 2'(k))]) begin
					pick = 2'(st_r.rr_last - 2'(k));
					pick_ok = 1'b1;
				end
			end
		end
	end

	// Next-state logic for the whole block
	always_comb begin
		st_nxt = st_r;
		st_nxt.slot1_s = {st_r.slot1_s[0], ~slot1_n};
		st_nxt.slot1_q = {st_r.slot1_q[0], st_r.slot1_s[1]};
		st_nxt.breq_s = {st_r.breq_s[3:0], ~bus_req_n};
		st_nxt.breq_q = st_r.breq_s[7:4];
		st_nxt.bbsy_s = {st_r.bbsy_s[0], ~bus_busy_n};
		st_nxt.bbsy_q = {st_r.bbsy_q[0], st_r.bbsy_s[1]};
		st_nxt.ds_s = {st_r.ds_s[0], ~data_strobe_n};
		st_nxt.ds_q = {st_r.ds_q[0], st_r.ds_s[1]};
		st_nxt.dtk_s = {st_r.dtk_s[0], ~dtack_n};
		st_nxt.dtk_q = {st_r.dtk_q[0], st_r.dtk_s[1]};
		st_nxt.pnl_s = {st_r.pnl_s[0], ~panel_reset_n};
		st_nxt.pnl_q = {st_r.pnl_q[0], st_r.pnl_s[1]};
		if (st_r.slot1_q == 2'h1) begin
			st_nxt.slot1_seen = 1'b1;
		end
		// Register writes; the two timeout status bits are write-one-to-clear
		if (wr_acc && paddr == arb_pkg::ctrl_off) begin
			st_nxt.ctrl = pwdata;
		end else if (wr_acc && paddr == arb_pkg::stat_off) begin
			if (pwdata[arb_pkg::st_arb_to_bit]) st_nxt.arb_to = 1'b0;
			if (pwdata[arb_pkg::st_bus_to_bit]) st_nxt.bus_to = 1'b0;
		end
		if (rd_acc && paddr == arb_pkg::ctrl_off) begin
			st_nxt.rdata = st_r.ctrl;
		end else if (rd_acc && paddr == arb_pkg::stat_off) begin
			st_nxt.rdata = {24'h0, st_r.grant, st_r.rstate == arb_pkg::req_own,
				sc_en, st_r.bus_to, st_r.arb_to};
		end else if (rd_acc) begin
			st_nxt.rdata = 32'h0;
		end
		// system clock divider
		// Parked low while disabled, but a high phase always completes,
		// so switching the controller off never leaves a runt pulse
		if (!sc_en && !st_r.sclk) begin
			st_nxt.sclk_div = 2'h0;
		end else if (st_r.sclk_div == 2'(arb_pkg::sysclk_half_cyc - 1)) begin
			st_nxt.sclk_div = 2'h0;
			st_nxt.sclk = ~st_r.sclk;
		end else begin
			st_nxt.sclk_div = st_r.sclk_div + 2'h1;
		end
		// Arbiter: one grant at a time, held until busy is seen or the grant times out
		if (!sc_en) begin
			st_nxt.grant = 4'h0;
			st_nxt.gcnt = 32'h0;
		end else if (st_r.grant != 4'h0) begin
			if (st_r.bbsy_q[1]) begin
				st_nxt.grant = 4'h0;
				st_nxt.gcnt = 32'h0;
			end else if (st_r.gcnt >= grant_limit - 32'h1) begin
				st_nxt.arb_to = 1'b1;
				st_nxt.grant = 4'h0;
				st_nxt.gcnt = 32'h0;
			end else begin
				st_nxt.gcnt = st_r.gcnt + 32'h1;
			end
		end else if (!st_r.bbsy_q[1] && pick_ok) begin
			st_nxt.grant = 4'h1 << pick;
			st_nxt.rr_last = pick;
		end
		if (sc_en && st_r.ds_q[1] && !st_r.dtk_q[1]) begin
			if (st_r.bcnt == 16'(arb_pkg::bto_unit_cyc *
				(32'h1 << st_r.ctrl[arb_pkg::ctl_bto_lsb +: 2]) - 1)) begin
				st_nxt.bus_to = 1'b1;
			end else begin
				st_nxt.bcnt = st_r.bcnt + 16'h1;
			end
		end else begin
			st_nxt.bcnt = 16'h0;
		end
		case (st_r.rstate)
			arb_pkg::req_idle: begin
				if (st_r.ctrl[arb_pkg::ctl_req_bit]) st_nxt.rstate = arb_pkg::req_wait;
			end
			arb_pkg::req_wait: begin
				if (!st_r.ctrl[arb_pkg::ctl_req_bit]) begin
					st_nxt.rstate = arb_pkg::req_idle;
				end else if (st_r.grant[lvl] && !st_r.bbsy_q[1]) begin
					st_nxt.rstate = arb_pkg::req_own;
				end
			end
			default: begin
				if (!st_r.ctrl[arb_pkg::ctl_req_bit] ||
					(policy == 2'(arb_pkg::release_on_request_policy) &&
						other_req && xfer_done) ||
					(policy == 2'(arb_pkg::release_when_done_policy) && xfer_done)) begin
					st_nxt.rstate = arb_pkg::req_idle;
					if (policy == 2'(arb_pkg::release_when_done_policy)) begin
						st_nxt.ctrl[arb_pkg::ctl_req_bit] = 1'b0;
					end
				end
			end
		endcase
		if (st_r.pnl_q[1]) begin
			st_nxt.rst_cnt = 5'(arb_pkg::reset_stretch_cyc);
		end else if (st_r.rst_cnt != 5'h0) begin
			st_nxt.rst_cnt = st_r.rst_cnt - 5'h1;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.ctrl <= arb_pkg::ctrl_reset;
			st_r.rstate <= arb_pkg::req_idle;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs; controller pins idle high when disabled, except sysclk, which parks low
	assign prdata = st_r.rdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign bus_grant_n = ~st_r.grant;
	assign own_req_n = ~(st_r.rstate == arb_pkg::req_wait ? 4'h1 << lvl : 4'h0);
	assign own_busy_n = ~(st_r.rstate == arb_pkg::req_own);
	assign bus_owner = st_r.rstate == arb_pkg::req_own;
	assign sysclk = st_r.sclk;
	assign iack_chain_n = !(sc_en && st_r.ds_q[1]);
	assign bus_error_n = !(sc_en && st_r.bus_to);
	assign sysreset_n = !(sc_en && st_r.rst_cnt != 5'h0);
	assign board_reset_n = st_r.rst_cnt == 5'h0;
endmodule

// ==== tb/arb_ctrl_properties.sv ====
// Port assertions for the arbitration controller
`timescale 1ns/1ps
module arb_ctrl_properties #(
	parameter int timeout_1ms_cyc = arb_pkg::cyc_1ms
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic panel_reset_n,
	input wire logic bus_busy_n,
	input wire logic [3:0] bus_grant_n,
	input wire logic [3:0] own_req_n,
	input wire logic own_busy_n,
	input wire logic bus_owner,
	input wire logic sysclk,
	input wire logic sysreset_n,
	input wire logic board_reset_n
);
	localparam int lim = arb_pkg::cyc_256 + timeout_1ms_cyc + 8;
	int unsigned idle_r;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Grant standing while nobody has taken the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idle_r <= 0;
		else
			idle_r <= (bus_grant_n != 4'hf && bus_busy_n) ? idle_r + 1 : 0;
	end
	sequence s_held; !board_reset_n [*8]; endsequence
	sequence s_pressed; $fell(panel_reset_n); endsequence
	property p_one_grant; $onehot0(~bus_grant_n); endproperty
	a_one_grant: assert property (p_one_grant)
		else $error("two grants at once");
	property p_one_level; $onehot0(~own_req_n); endproperty
	a_one_level: assert property (p_one_level)
		else $error("own request on two levels");
	property p_owner; bus_owner == !own_busy_n; endproperty
	a_owner: assert property (p_owner)
		else $error("owner flag and busy disagree");
	property p_own_wait; $fell(own_busy_n) |-> $past(own_req_n) != 4'hf;
	endproperty
	a_own_wait: assert property (p_own_wait)
		else $error("bus taken without a request");
	property p_grant_bound; idle_r <= lim; endproperty
	a_grant_bound: assert property (p_grant_bound)
		else $error("untaken grant never withdrawn");
	property p_panel; s_pressed |-> ##[1:6] !board_reset_n; endproperty
	a_panel: assert property (p_panel)
		else $error("panel press did not reset board");
	property p_stretch; $fell(board_reset_n) |=> s_held; endproperty
	a_stretch: assert property (p_stretch)
		else $error("board reset too short");
	property p_sys_reset; !sysreset_n |-> !board_reset_n; endproperty
	a_sys_reset: assert property (p_sys_reset)
		else $error("system reset without board reset");
	property p_sysclk; $rose(sysclk) |=> sysclk; endproperty
	a_sysclk: assert property (p_sysclk)
		else $error("system clock high phase too short");
endmodule
bind arb_ctrl arb_ctrl_properties #(.timeout_1ms_cyc(timeout_1ms_cyc)) u_prop (
	.pclk(pclk), .presetn(presetn), .panel_reset_n(panel_reset_n),
	.bus_busy_n(bus_busy_n), .bus_grant_n(bus_grant_n),
	.own_req_n(own_req_n), .own_busy_n(own_busy_n), .bus_owner(bus_owner),
	.sysclk(sysclk), .sysreset_n(sysreset_n), .board_reset_n(board_reset_n));

// ==== tb/arb_ctrl_tb_top.sv ====
// Self-checking bench for the arbitration controller
`timescale 1ns/1ps
`define chk(a, e) \
	begin \
		samples_checked++; \
		if ((a) !== (e)) begin \
			fail_count++; \
			$display("wrong value at %0t: %h vs %h", $time, a, e); \
		end \
	end
module arb_ctrl_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r, ctrl_m;
	logic slot1_n = 0, panel_reset_n = 1, xfer_done = 0, pready, pslverr;
	logic own_busy_n, bus_owner, sysclk, iack_n, bus_error_n, sysreset_n;
	logic board_reset_n, far_busy_n, strobe_n, dtack_n;
	logic [3:0] bus_grant_n, own_req_n, far_req_n;
	int fail_count = 0, samples_checked = 0, seed = 58, n;
	bit got;
	always #10 pclk = ~pclk;
	arb_ctrl #(.timeout_1ms_cyc(100)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.slot1_n(slot1_n), .bus_req_n(far_req_n & own_req_n),
		.bus_busy_n(far_busy_n & own_busy_n), .data_strobe_n(strobe_n),
		.dtack_n(dtack_n), .panel_reset_n(panel_reset_n),
		.xfer_done(xfer_done), .bus_grant_n(bus_grant_n),
		.own_req_n(own_req_n), .own_busy_n(own_busy_n), .bus_owner(bus_owner),
		.sysclk(sysclk), .iack_chain_n(iack_n), .bus_error_n(bus_error_n),
		.sysreset_n(sysreset_n), .board_reset_n(board_reset_n));
	far_boards u_far (.pclk(pclk), .bus_grant_n(bus_grant_n),
		.far_req_n(far_req_n), .far_busy_n(far_busy_n),
		.strobe_n(strobe_n), .dtack_n(dtack_n));
	// One APB transfer; the control copy tracks every write
	task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		r = prdata;
		psel <= 0;
		penable <= 0;
		if (w && a == arb_pkg::ctrl_off)
			ctrl_m = d & 32'h37ff;
	endtask
	task automatic end_of_test();
		$display("checked %0d, wrong %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Hang guard well beyond the expected run
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, arb_pkg::ctrl_off, 0);
		`chk(r, arb_pkg::ctrl_reset)
		apb(0, 12'h100, 0);
		`chk(r, 32'h0)
		repeat (6) @(posedge pclk);
		apb(0, arb_pkg::stat_off, 0);
		`chk(r[arb_pkg::st_sc_bit], 1'b1)
		for (int k = 0; k < 3; k++) begin
			apb(1, 0, ($random(seed) & 32'h30c0) | (k << 8) | (k << 2) | 32'h30);
			apb(0, 0, 0);
			`chk(r & 32'h37ff, ctrl_m)
			u_far.transfer(k == 1 ? 3 : ctrl_m[7:6], k + 1, 3, got);
			`chk(got, 1'b1)
		end
		$display("register and mode test done");
		// Count rises over 80 consecutive cycles, whole periods only
		n = 0;
		@(negedge pclk);
		for (int k = 0; k < 80; k++) begin
			r[0] = sysclk;
			@(negedge pclk);
			n += (sysclk && !r[0]) ? 1 : 0;
		end
		`chk(n, 80 / (2 * arb_pkg::sysclk_half_cyc))
		@(posedge pclk);
		u_far.transfer(1, -1, 0, got);
		repeat (250) @(posedge pclk);
		apb(0, arb_pkg::stat_off, 0);
		`chk(r[0], 1'b1)
		apb(1, arb_pkg::stat_off, 1);
		apb(0, arb_pkg::stat_off, 0);
		`chk(r[0], 1'b0)
		// Strobe stands past the chosen bus timeout plus sync latency
		fork
			u_far.transfer(2, 0, (arb_pkg::bto_unit_cyc << ctrl_m[13:12]) + 8,
				got);
			begin
				wait (!strobe_n);
				repeat (8) @(posedge pclk);
				`chk(iack_n, 1'b0)
				`chk(bus_error_n, 1'b1)
			end
		join
		`chk(got, 1'b1)
		`chk(bus_error_n, 1'b0)
		$display("timeout test done");
		apb(1, 0, 32'h0000_05b0);
		for (n = 0; n < 300 && !bus_owner; n++)
			@(negedge pclk);
		`chk(bus_owner, 1'b1)
		@(posedge pclk);
		xfer_done <= 1;
		@(posedge pclk);
		xfer_done <= 0;
		repeat (6) @(posedge pclk);
		`chk(bus_owner, 1'b0)
		apb(0, 0, 0);
		`chk(r[10], 1'b0)
		// Release on request: a waiting board plus done hands over
		apb(1, 0, 32'h0000_0430);
		for (n = 0; n < 300 && !bus_owner; n++)
			@(negedge pclk);
		`chk(bus_owner, 1'b1)
		@(posedge pclk);
		fork
			u_far.transfer(1, 0, 3, got);
			begin
				repeat (8) @(posedge pclk);
				`chk(bus_owner, 1'b1)
				xfer_done <= 1;
				@(posedge pclk);
				xfer_done <= 0;
			end
		join
		`chk(got, 1'b1)
		// Capture and hold: done alone does not give the bus up
		apb(1, 0, 32'h0000_0630);
		for (n = 0; n < 300 && !bus_owner; n++)
			@(negedge pclk);
		@(posedge pclk);
		xfer_done <= 1;
		@(posedge pclk);
		xfer_done <= 0;
		repeat (6) @(posedge pclk);
		`chk(bus_owner, 1'b1)
		apb(1, 0, 32'h0000_0030);
		repeat (4) @(posedge pclk);
		`chk(bus_owner, 1'b0)
		panel_reset_n <= 0;
		repeat (8) @(posedge pclk);
		`chk(sysreset_n, 1'b0)
		`chk(board_reset_n, 1'b0)
		panel_reset_n <= 1;
		// Disabled controller: no system clock, panel resets board only
		repeat (30) @(posedge pclk);
		apb(1, 0, 32'h0000_0002);
		apb(0, arb_pkg::stat_off, 0);
		`chk(r[arb_pkg::st_sc_bit], 1'b0)
		n = 0;
		repeat (8) begin
			@(posedge pclk);
			n += (sysclk !== 1'b0) ? 1 : 0;
		end
		`chk(n, 0)
		panel_reset_n <= 0;
		repeat (8) @(posedge pclk);
		`chk(sysreset_n, 1'b1)
		`chk(board_reset_n, 1'b0)
		panel_reset_n <= 1;
		$display("requester and reset test done");
		end_of_test();
	end
endmodule

// ==== tb/far_boards.sv ====
// Model of the other boards' requesters and masters
`timescale 1ns/1ps
module far_boards (
	input wire logic pclk,
	input wire logic [3:0] bus_grant_n,
	output logic [3:0] far_req_n = 4'hf,
	output logic far_busy_n = 1'b1,
	output logic strobe_n = 1'b1,
	output logic dtack_n = 1'b1
);
	// Lines are pulled up, so a released line reads high
	task automatic transfer(input int lvl, dly, hold, output bit got);
		int n;
		n = 0;
		far_req_n[lvl] <= 1'b0;
		while (bus_grant_n[lvl] && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		got = !bus_grant_n[lvl];
		// A negative delay never takes the grant up
		while (dly < 0 && !bus_grant_n[lvl])
			@(negedge pclk);
		// Changes always follow a rising edge, also on the untaken path
		repeat (dly < 0 ? 1 : dly + 1) @(posedge pclk);
		if (dly >= 0) begin
			far_busy_n <= 1'b0;
			strobe_n <= 1'b0;
		end
		far_req_n[lvl] <= 1'b1;
		repeat (hold) @(posedge pclk);
		dtack_n <= 1'b0;
		@(posedge pclk);
		far_busy_n <= 1'b1;
		strobe_n <= 1'b1;
		dtack_n <= 1'b1;
	endtask
endmodule
